// ### hw/can_expander_msg_handler.sv
// power-up, bus join and message functions of the can i/o expander
`timescale 1ns/1ps
`default_nettype none
`include "msg_handler_map.svh"
//
// Contract
// - transmit pin stays high until on bus
// - config mode: no messages, peripherals disabled
// - copy nonvolatile array, then verify checksum
// - listen-only until one error-free message
// - then wait bus idle, enter normal
// - power-up-normal bit skips listen-only mode
// - announce once; repeat only when scheduled
// - select bit: readout data, autoconv identifier
// - first announcement never carries readout data
// - sleep suspends scheduled transmissions
// - filter 0 requests, filter 1 inputs
// - request type bit, zero means remote
// - mismatching rtr request ignored silently
// - function from three low identifier bits
// - single register read needs extended id
// - remote answer: same id, received dlc
// - short dlc truncates, long repeats last
// - data answer clears identifier bit 3
// - input message low bits pick group
// - register write applies supplied bit mask
// - one message at a time, extras dropped
module can_expander_msg_handler
    import msg_handler_pkg::*;
#(
    parameter int unsigned SCHED_UNIT_CYC = `SCHED_UNIT_CYC
) (
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     arst_n,
    // nonvolatile configuration array, combinational read
    output logic [5:0]                    nvm_addr,
    input  wire logic [7:0]               nvm_data,
    // can controller receive side
    input  wire logic                     rx_valid,
    input  wire msg_handler_pkg::can_frame_s rx_frame,
    input  wire logic                     rx_ok,
    input  wire logic                     bus_idle,
    // can controller transmit side
    output logic                          tx_valid,
    input  wire logic                     tx_ready,
    output msg_handler_pkg::can_frame_s   tx_frame,
    input  wire logic                     can_tx_bit,
    output logic                          can_tx_pin,
    // peripheral data and power state
    input  wire logic [7:0][7:0]          adc_bytes,
    output logic [2:0]                    rd_sel,
    input  wire logic [7:0][7:0]          rd_data,
    input  wire logic                     sleep,
    // status
    output logic                          cfg_mode,
    output logic                          listen_mode,
    output logic                          normal_mode,
    output logic                          periph_en,
    output logic                          cfg_error,
    output logic                          rx_lost,
    output msg_handler_pkg::cfg_mem_t     cfg_mem
);
    import msg_handler_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [28:0] id_of(cfg_mem_t m, logic [5:0] b, logic ext);
        if (ext) begin
            return {m[b], m[b+6'h1][7:5], m[b+6'h1][1:0], m[b+6'h2], m[b+6'h3]};
        end
        return {18'h0, m[b], m[b+6'h1][7:5]};
    endfunction : id_of

    function automatic logic accept(cfg_mem_t m, logic [5:0] fb, can_frame_s f);
        logic [28:0] msk;
        msk = id_of(m, `OFS_ACCEPT_MASK, f.ide);
        return (((f.id ^ id_of(m, fb, f.ide)) & msk) == 29'h0)
               && (m[fb+6'h1][`BIT_EXIDE] == f.ide);
    endfunction : accept

    function automatic logic [3:0] def_len(logic [2:0] fn);
        case (fn)
            3'h1:    return 4'h7;
            3'h2:    return 4'h5;
            3'h3:    return 4'h3;
            3'h4:    return 4'h6;
            3'h7:    return 4'h1;
            default: return 4'h8;
        endcase
    endfunction : def_len

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_s s_q;
    state_s s_d;
    logic [7:0] opt2;
    logic [7:0] sctl;
    logic [2:0] fn;
    logic       req_data;
    logic       on_bus;
    logic [31:0] ivl;
    logic [7:0][7:0] src;
    logic [3:0] dl;
    logic [5:0] wa;
    logic [5:0] gb;

    assign opt2     = s_q.mem[`OFS_OPTION_TWO];
    assign sctl     = s_q.mem[`OFS_SCHED_CTRL];
    assign req_data = opt2[`BIT_REQ_TYPE];
    assign fn       = s_q.rx.id[2:0];
    assign on_bus   = s_q.st inside {S_NORMAL, S_PROC, S_SEND};
    assign ivl      = 32'(({28'h0, sctl[`SCHED_IVL_W-1:0]} + 32'h1) * SCHED_UNIT_CYC);

    always_comb begin
        s_d        = s_q;
        s_d.lost   = 1'b0;
        src        = rd_data;
        dl         = def_len(fn);
        wa         = 6'h0;
        gb         = 6'h0;
        // busy with a message: anything else completing now is lost
        if (rx_valid && s_q.st inside {S_PROC, S_SEND}) begin
            s_d.lost = 1'b1;
        end
        unique case (s_q.st)
            S_LOAD: begin
                s_d.mem[s_q.idx] = nvm_data;
                s_d.sum          = s_q.sum + nvm_data;
                s_d.idx          = s_q.idx + 6'h1;
                if (s_q.idx == `CFG_LAST) begin
                    s_d.st = S_CHECK;
                end
            end
            S_CHECK: begin
                if (nvm_data != s_q.sum) begin
                    s_d.st = S_FAIL;
                end else if (opt2[`BIT_PWR_NORMAL]) begin
                    s_d.st         = S_NORMAL;
                    s_d.onbus_pend = 1'b1;
                end else begin
                    s_d.st = S_LISTEN;
                end
            end
            S_FAIL: begin
                s_d.st = S_FAIL;
            end
            S_LISTEN: begin
                if (rx_ok) begin
                    s_d.st = S_IDLEW;
                end
            end
            S_IDLEW: begin
                if (bus_idle) begin
                    s_d.st         = S_NORMAL;
                    s_d.onbus_pend = 1'b1;
                end
            end
            S_NORMAL: begin
                if (rx_valid) begin
                    s_d.rx     = rx_frame;
                    s_d.hit0   = accept(s_q.mem, `OFS_REQ_FILTER, rx_frame);
                    s_d.hit1   = accept(s_q.mem, `OFS_IN_FILTER, rx_frame);
                    s_d.rd_sel = rx_frame.id[2:0];
                    s_d.st     = S_PROC;
                end else if (s_q.onbus_pend && !sleep) begin
                    // the announcement never carries readout bytes
                    s_d.onbus_pend = 1'b0;
                    s_d.tx         = '0;
                    {s_d.tx.ide, s_d.tx.id} = {s_q.mem[`OFS_ONBUS_ID+6'h1][`BIT_EXIDE],
                        id_of(s_q.mem, `OFS_ONBUS_ID,
                              s_q.mem[`OFS_ONBUS_ID+6'h1][`BIT_EXIDE])};
                    s_d.st = S_SEND;
                end else if (s_q.sched_pend && !sleep) begin
                    s_d.sched_pend = 1'b0;
                    s_d.tx         = '0;
                    gb = sctl[`BIT_SCHED_SEL] ? `OFS_AUTOCONV_ID : `OFS_ONBUS_ID;
                    s_d.tx.ide = s_q.mem[gb+6'h1][`BIT_EXIDE];
                    s_d.tx.id  = id_of(s_q.mem, gb, s_q.mem[gb+6'h1][`BIT_EXIDE]);
                    if (sctl[`BIT_SCHED_SEL]) begin
                        s_d.tx.dlc  = 4'h8;
                        s_d.tx.data = adc_bytes;
                    end
                    s_d.st = S_SEND;
                end
            end
            S_PROC: begin
                s_d.st = S_NORMAL;
                if (s_q.hit0) begin
                    if (fn == 3'h0) begin
                        src = adc_bytes;
                    end else if (fn == 3'h7) begin
                        wa     = s_q.rx.id[13:8];
                        src    = '0;
                        src[0] = (s_q.rx.id[15:8] < 8'(`CFG_BYTES)) ? s_q.mem[wa] : 8'h0;
                    end
                    // answer only the selected frame type; register read needs an extended id
                    if ((s_q.rx.rtr != req_data) && !(fn == 3'h7 && !s_q.rx.ide)) begin
                        s_d.tx     = s_q.rx;
                        s_d.tx.rtr = 1'b0;
                        s_d.tx.dlc = req_data ? dl : s_q.rx.dlc;
                        if (req_data) begin
                            s_d.tx.id[3] = 1'b0;
                        end
                        for (int i = 0; i < 8; i++) begin
                            s_d.tx.data[i] = (4'(i) < dl) ? src[i] : src[dl-4'h1];
                        end
                        s_d.st = S_SEND;
                    end
                end else if (s_q.hit1 && !s_q.rx.rtr) begin
                    unique case (fn)
                        3'h0: begin
                            wa = s_q.rx.data[0][5:0];
                            if (s_q.rx.data[0] < 8'(`CFG_BYTES)) begin
                                s_d.mem[wa] = (s_q.mem[wa] & ~s_q.rx.data[1])
                                            | (s_q.rx.data[2] & s_q.rx.data[1]);
                            end
                        end
                        3'h4: begin
                            s_d.mem[`OFS_IOINTEN] = s_q.rx.data[0];
                            s_d.mem[`OFS_IOINTPO] = s_q.rx.data[1];
                            s_d.mem[`OFS_GPDDR]   = s_q.rx.data[2];
                            s_d.mem[`OFS_OPTREG1] = s_q.rx.data[3];
                            s_d.mem[`OFS_ADCON1]  = s_q.rx.data[4];
                        end
                        default: begin
                            case (fn)
                                3'h1:    gb = `OFS_ONBUS_ID;
                                3'h2:    gb = `OFS_ACK_ID;
                                3'h3:    gb = `OFS_AUTOCONV_ID;
                                3'h5:    gb = `OFS_ACCEPT_MASK;
                                3'h6:    gb = `OFS_REQ_FILTER;
                                default: gb = `OFS_IN_FILTER;
                            endcase
                            for (int i = 0; i < 4; i++) begin
                                s_d.mem[gb+6'(i)] = s_q.rx.data[i];
                            end
                        end
                    endcase
                end
            end
            S_SEND: begin
                if (tx_ready) begin
                    s_d.st = S_NORMAL;
                end
            end
            default: begin
                s_d.st = S_FAIL;
            end
        endcase
        // timer after the case: a period that ends as the last one is sent is kept
        if (on_bus && sctl[`BIT_SCHED_EN] && !sleep) begin
            s_d.tmr = s_q.tmr + 32'h1;
            if (s_q.tmr + 32'h1 >= ivl) begin
                s_d.tmr        = 32'h0;
                s_d.sched_pend = 1'b1;
            end
        end
        // pin held recessive off bus, flop so it never glitches
        s_d.pin = on_bus ? can_tx_bit : 1'b1;
        if (s_d.st inside {S_LOAD, S_CHECK, S_FAIL, S_LISTEN, S_IDLEW}) begin
            s_d.pin = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q     <= '0;
            s_q.st  <= S_LOAD;
            s_q.pin <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign nvm_addr    = s_q.idx;
    assign tx_valid    = (s_q.st == S_SEND);
    assign tx_frame    = s_q.tx;
    assign can_tx_pin  = s_q.pin;
    assign rd_sel      = s_q.rd_sel;
    assign cfg_mode    = s_q.st inside {S_LOAD, S_CHECK, S_FAIL};
    assign listen_mode = s_q.st inside {S_LISTEN, S_IDLEW};
    assign normal_mode = on_bus;
    assign periph_en   = on_bus;
    assign cfg_error   = (s_q.st == S_FAIL);
    assign rx_lost     = s_q.lost;
    assign cfg_mem     = s_q.mem;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_heard;
        s_q.st == S_LISTEN && rx_ok;
    endsequence
    sequence s_idle_seen;
        s_q.st == S_IDLEW && bus_idle;
    endsequence
    a_pin_recessive: assert property (!normal_mode |-> can_tx_pin)
        else $error("transmit pin driven low off bus");
    a_cfg_quiet: assert property (cfg_mode |-> !tx_valid && !periph_en && can_tx_pin)
        else $error("activity in configuration mode");
    a_load_check: assert property (s_q.st == S_LOAD && s_q.idx == `CFG_LAST |=> s_q.st == S_CHECK && nvm_addr == `CKSUM_ADDR)
        else $error("checksum step missed");
    a_listen_join: assert property (s_heard |=> s_q.st == S_IDLEW)
        else $error("listen-only join sequence broken");
    a_listen_stay: assert property (s_q.st == S_LISTEN && !rx_ok |=> s_q.st == S_LISTEN)
        else $error("left listen-only without a message");
    a_idle_join: assert property (s_idle_seen |=> normal_mode && s_q.onbus_pend)
        else $error("idle bus did not lead onto the bus");
    a_idle_wait: assert property (s_q.st == S_IDLEW && !bus_idle |=> !normal_mode)
        else $error("joined bus while not idle");
    a_power_normal: assert property (s_q.st == S_CHECK && nvm_data == s_q.sum && opt2[`BIT_PWR_NORMAL] |=> normal_mode && s_q.onbus_pend)
        else $error("power-up normal option ignored");
    a_sleep_hold: assert property (sleep && s_q.st == S_NORMAL && !rx_valid |=> !tx_valid)
        else $error("transmit started during sleep");
    a_type_ignore: assert property (s_q.st == S_PROC && s_q.hit0 && s_q.rx.rtr == req_data |=> s_q.st == S_NORMAL)
        else $error("mismatching request answered");
    a_read_ext: assert property (s_q.st == S_PROC && s_q.hit0 && fn == 3'h7 && !s_q.rx.ide |=> !tx_valid)
        else $error("register read on standard id answered");
    a_data_bit3: assert property (s_q.st == S_PROC && s_q.hit0 && req_data && !s_q.rx.rtr
        && !(fn == 3'h7 && !s_q.rx.ide) |=> tx_valid && !tx_frame.id[3] && tx_frame.id[28:4] == $past(s_q.rx.id[28:4]))
        else $error("data answer identifier wrong");
    a_rx_drop: assert property (rx_valid && s_q.st inside {S_PROC, S_SEND} |=> rx_lost && s_q.rx == $past(s_q.rx))
        else $error("second message not dropped");
endmodule : can_expander_msg_handler
`default_nettype wire

// ### hw/msg_handler_map.svh
// offsets, field positions and timing counts of the message handler
`ifndef MSG_HANDLER_MAP_SVH
`define MSG_HANDLER_MAP_SVH
`define CFG_BYTES        53
`define CFG_LAST         6'h34
`define CKSUM_ADDR       6'h35
`define OFS_IOINTEN      6'h00
`define OFS_IOINTPO      6'h01
`define OFS_OPTREG1      6'h04
`define OFS_ADCON1       6'h0f
`define OFS_SCHED_CTRL   6'h10
`define OFS_OPTION_TWO   6'h11
`define OFS_ACCEPT_MASK  6'h14
`define OFS_REQ_FILTER   6'h18
`define OFS_IN_FILTER    6'h1c
`define OFS_ONBUS_ID     6'h20
`define OFS_ACK_ID       6'h24
`define OFS_AUTOCONV_ID  6'h28
`define OFS_GPDDR        6'h34
`define BIT_PWR_NORMAL   0
`define BIT_REQ_TYPE     1
`define BIT_SCHED_EN     7
`define BIT_SCHED_SEL    6
`define BIT_EXIDE        3
`define SCHED_IVL_W      4
`define CLK_PERIOD_NS    5
`define SCHED_UNIT_NS    1000000
`define SCHED_UNIT_CYC   (`SCHED_UNIT_NS / `CLK_PERIOD_NS)
`endif

// ### hw/msg_handler_pkg.sv
// types shared by the message handler
`include "msg_handler_map.svh"
package msg_handler_pkg;
    typedef struct packed {
        logic [28:0]     id;
        logic            ide;
        logic            rtr;
        logic [3:0]      dlc;
        logic [7:0][7:0] data;
    } can_frame_s;
    typedef logic [`CFG_BYTES-1:0][7:0] cfg_mem_t;
    typedef enum logic [7:0] {
        S_LOAD   = 8'h01,
        S_CHECK  = 8'h02,
        S_FAIL   = 8'h04,
        S_LISTEN = 8'h08,
        S_IDLEW  = 8'h10,
        S_NORMAL = 8'h20,
        S_PROC   = 8'h40,
        S_SEND   = 8'h80
    } mode_e;
    typedef struct packed {
        mode_e      st;
        logic [5:0] idx;
        logic [7:0] sum;
        cfg_mem_t   mem;
        can_frame_s rx;
        logic       hit0;
        logic       hit1;
        can_frame_s tx;
        logic       onbus_pend;
        logic       sched_pend;
        logic [31:0] tmr;
        logic       pin;
        logic       lost;
        logic [2:0] rd_sel;
    } state_s;
endpackage : msg_handler_pkg

// ### hw/unused_placeholder_none.sv
// intentionally empty design file slot
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### verif/can_node_model.sv
// far-side can node that takes the expander's transmit requests after a chosen stall
`timescale 1ns/1ps
`default_nettype none
module can_node_model
    import msg_handler_pkg::*;
(
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        arst_n,
    // transmit handshake with the expander
    input  wire logic                        tx_valid,
    input  wire msg_handler_pkg::can_frame_s tx_frame,
    output logic                             tx_ready,
    // stall length and what was taken off the bus
    input  wire logic [2:0]                  stall,
    output int                               tx_count,
    output msg_handler_pkg::can_frame_s      last_tx
);
    logic [2:0] wait_cnt;

    // ready is dropped right after each handshake so one frame is never counted twice
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_ready <= 1'b0;
            wait_cnt <= 3'h0;
            tx_count <= 0;
            last_tx  <= '0;
        end else if (tx_ready) begin
            tx_ready <= 1'b0;
            tx_count <= tx_count + 1;
            last_tx  <= tx_frame;
        end else if (tx_valid) begin
            if (wait_cnt >= stall) begin
                tx_ready <= 1'b1;
                wait_cnt <= 3'h0;
            end else begin
                wait_cnt <= wait_cnt + 3'h1;
            end
        end
    end
endmodule : can_node_model
`default_nettype wire

// ### verif/can_expander_msg_handler_bench.sv
// self-checking testbench of the message handler
`timescale 1ns/1ps
`default_nettype none
`include "msg_handler_map.svh"
module can_expander_msg_handler_bench;
    import msg_handler_pkg::*;
    logic ref_clk = 1'b0, arst_n = 1'b0, rx_valid = 1'b0, rx_ok = 1'b0, bus_idle = 1'b0;
    logic sleep = 1'b1, corrupt = 1'b0, alt = 1'b0, off_bad = 1'b0, lost_seen = 1'b0;
    logic [2:0]      stall = 3'h0;
    logic [5:0]      nvm_addr;
    logic [7:0]      nvm_data;
    can_frame_s      rx_frame = '0, tx_frame, last_tx;
    cfg_mem_t        cfg_mem;
    logic            tx_valid, tx_ready, can_tx_pin, cfg_mode, listen_mode, normal_mode;
    logic            periph_en, cfg_error, rx_lost;
    logic [2:0]      rd_sel;
    logic [7:0][7:0] adc = 64'hf8e7d6c5b4a39281, rdd = 64'h8877665544332211;
    int              bad_count = 0, cmp_count = 0, tx_count;
    int              len [8] = '{8, 7, 5, 3, 6, 8, 8, 1};

    always #2.5 ref_clk = ~ref_clk;

    can_expander_msg_handler #(.SCHED_UNIT_CYC(4)) dut_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .nvm_addr(nvm_addr), .nvm_data(nvm_data),
        .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ok(rx_ok), .bus_idle(bus_idle),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame), .can_tx_bit(1'b0),
        .can_tx_pin(can_tx_pin), .adc_bytes(adc), .rd_sel(rd_sel), .rd_data(rdd), .sleep(sleep),
        .cfg_mode(cfg_mode), .listen_mode(listen_mode), .normal_mode(normal_mode),
        .periph_en(periph_en), .cfg_error(cfg_error), .rx_lost(rx_lost), .cfg_mem(cfg_mem));
    can_node_model node_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .tx_valid(tx_valid), .tx_frame(tx_frame),
        .tx_ready(tx_ready), .stall(stall), .tx_count(tx_count), .last_tx(last_tx));

    // mask checks sid bit 10 only: clear goes to requests, set to input messages
    function automatic logic [7:0] cfg_byte(input logic [5:0] a, input logic alt_cfg);
        case (a)
            `OFS_SCHED_CTRL:                 return 8'hc0;
            `OFS_OPTION_TWO:                 return alt_cfg ? 8'h03 : 8'h00;
            `OFS_ACCEPT_MASK, `OFS_IN_FILTER: return 8'h80;
            `OFS_ONBUS_ID:                   return 8'h12;
            `OFS_AUTOCONV_ID:                return 8'h34;
            default:                         return 8'h00;
        endcase
    endfunction : cfg_byte
    function automatic logic [7:0] cksum(input logic alt_cfg);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < `CFG_BYTES; i++) s = s + cfg_byte(i[5:0], alt_cfg);
        return s;
    endfunction : cksum
    function automatic can_frame_s req(input logic [10:0] sid, input logic rtr,
                                       input logic [3:0] dlc, input logic [63:0] d);
        can_frame_s f;
        f = '0;
        f.id = {18'h0, sid};
        f.rtr = rtr;
        f.dlc = dlc;
        f.data = d;
        return f;
    endfunction : req

    always_comb begin
        nvm_data = 8'h00;
        if (nvm_addr == `CKSUM_ADDR) nvm_data = cksum(alt) ^ {7'h0, corrupt};
        else if (nvm_addr <= `CFG_LAST) nvm_data = cfg_byte(nvm_addr, alt);
    end
    // off the bus the pin stays recessive and nothing is offered
    always @(negedge ref_clk) begin
        if (normal_mode !== 1'b1 && (can_tx_pin !== 1'b1 || tx_valid !== 1'b0)) off_bad <= 1'b1;
        if (cfg_mode === 1'b1 && periph_en !== 1'b0) off_bad <= 1'b1;
    end
    always @(posedge ref_clk) if (rx_lost === 1'b1) lost_seen <= 1'b1;

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic give_verdict();
        if (bad_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    task automatic send(input can_frame_s f);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_frame <= f;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
    endtask : send
    task automatic wait_tx(input int n);
        for (int i = 0; i < 80 && tx_count != n; i++) @(posedge ref_clk);
        chk("tx_count", n, tx_count);
    endtask : wait_tx
    task automatic expect_ans(input int n, input logic [10:0] id, input logic [3:0] dlc,
                              input logic [63:0] d);
        logic [63:0] m;
        wait_tx(n);
        m = (dlc >= 8) ? '1 : ((64'h1 << (8 * dlc)) - 64'h1);
        chk("tx_id", {53'h0, id}, {35'h0, last_tx.id});
        chk("tx_rtr", 0, last_tx.rtr);
        chk("tx_dlc", dlc, last_tx.dlc);
        chk("tx_data", d & m, last_tx.data & m);
    endtask : expect_ans
    task automatic boot(input logic bad, input logic alt_cfg);
        @(posedge ref_clk);
        arst_n  <= 1'b0;
        corrupt <= bad;
        alt     <= alt_cfg;
        sleep   <= 1'b1;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        send(req(11'h02b, 1'b1, 4'h3, 64'h0));
        for (int i = 0; i < 100 && cfg_mode !== 1'b0; i++) @(posedge ref_clk);
    endtask : boot

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_bad_cksum();
        boot(1'b1, 1'b0);
        chk("cfg_error", 1, cfg_error);
        chk("cfg_mode", 1, cfg_mode);
    endtask : t_bad_cksum
    task automatic t_join();
        boot(1'b0, 1'b0);
        for (int i = 0; i < `CFG_BYTES; i++)
            chk("cfg_mem", cfg_byte(i[5:0], 1'b0), cfg_mem[i]);
        chk("cfg_ok", 0, cfg_error);
        chk("listen", 1, listen_mode);
        repeat (20) @(posedge ref_clk);
        chk("normal_early", 0, normal_mode);
        @(posedge ref_clk) rx_ok <= 1'b1;
        @(posedge ref_clk) rx_ok <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk("normal_busy", 0, normal_mode);
        bus_idle <= 1'b1;
        for (int i = 0; i < 20 && normal_mode !== 1'b1; i++) @(posedge ref_clk);
        chk("periph_en", 1, periph_en);
        repeat (30) @(posedge ref_clk);
        chk("asleep_tx", 0, tx_count);
    endtask : t_join
    task automatic t_reads();
        logic [7:0][7:0] e, src;
        int n = tx_count;
        stall <= 3'h4;
        for (int fn = 0; fn < 7; fn++) begin
            src = (fn == 0) ? adc : rdd;
            for (int k = 0; k < 8; k++) e[k] = src[(k < len[fn]) ? k : len[fn] - 1];
            send(req(11'h028 | 11'(fn), 1'b1, 4'h8, 64'h0));
            expect_ans(++n, 11'h028 | 11'(fn), 4'h8, e);
            chk("rd_sel", fn, rd_sel);
        end
        send(req(11'h029, 1'b1, 4'h3, 64'h0));
        expect_ans(++n, 11'h029, 4'h3, rdd);
        stall <= 3'h0;
    endtask : t_reads
    task automatic t_ignored();
        int n = tx_count;
        send(req(11'h023, 1'b0, 4'h3, 64'h0));
        send(req(11'h02f, 1'b1, 4'h1, 64'h0));
        send(req(11'h403, 1'b1, 4'h4, 64'h0));
        repeat (30) @(posedge ref_clk);
        chk("ignored_tx", n, tx_count);
    endtask : t_ignored
    task automatic t_overlap();
        int n = tx_count + 1;
        @(posedge ref_clk);
        lost_seen <= 1'b0;
        rx_valid  <= 1'b1;
        rx_frame  <= req(11'h02b, 1'b1, 4'h3, 64'h0);
        @(posedge ref_clk) rx_frame <= req(11'h029, 1'b1, 4'h7, 64'h0);
        @(posedge ref_clk) rx_valid <= 1'b0;
        expect_ans(n, 11'h02b, 4'h3, rdd);
        repeat (30) @(posedge ref_clk);
        chk("second_dropped", n, tx_count);
        chk("rx_lost", 1, lost_seen);
    endtask : t_overlap
    task automatic t_inputs();
        send(req(11'h404, 1'b0, 4'h5, 64'h0f817e5a3c));
        repeat (4) @(posedge ref_clk);
        chk("iointen", 8'h3c, cfg_mem[`OFS_IOINTEN]);
        chk("iointpo", 8'h5a, cfg_mem[`OFS_IOINTPO]);
        chk("gpddr", 8'h7e, cfg_mem[`OFS_GPDDR]);
        chk("optreg1", 8'h81, cfg_mem[`OFS_OPTREG1]);
        chk("adcon1", 8'h0f, cfg_mem[`OFS_ADCON1]);
        send(req(11'h402, 1'b0, 4'h4, 64'h44332211));
        repeat (4) @(posedge ref_clk);
        chk("ack_id_lo", 8'h11, cfg_mem[`OFS_ACK_ID]);
        chk("ack_id_hi", 8'h44, cfg_mem[`OFS_ACK_ID + 6'h3]);
        send(req(11'h400, 1'b0, 4'h3, 64'ha50f00));
        repeat (4) @(posedge ref_clk);
        chk("masked_write", 8'h35, cfg_mem[`OFS_IOINTEN]);
    endtask : t_inputs
    task automatic t_sched();
        int n = tx_count;
        sleep <= 1'b0;
        expect_ans(n + 1, 11'h090, 4'h0, 64'h0);
        expect_ans(n + 2, 11'h1a0, 4'h8, adc);
        expect_ans(n + 3, 11'h1a0, 4'h8, adc);
        chk("pin_on_bus", 0, can_tx_pin);
    endtask : t_sched
    task automatic t_data_mode();
        boot(1'b0, 1'b1);
        for (int i = 0; i < 20 && normal_mode !== 1'b1; i++) @(posedge ref_clk);
        chk("direct_normal", 1, normal_mode);
        send(req(11'h02b, 1'b0, 4'h0, 64'h0));
        expect_ans(tx_count + 1, 11'h023, 4'h3, rdd);
        send(req(11'h02b, 1'b1, 4'h3, 64'h0));
        repeat (30) @(posedge ref_clk);
        chk("rtr_in_data_mode", 1, tx_count);
        chk("off_bus_quiet", 0, off_bad);
    endtask : t_data_mode

    initial begin
        t_bad_cksum();
        t_join();
        t_reads();
        t_ignored();
        t_overlap();
        t_inputs();
        t_sched();
        t_data_mode();
        give_verdict();
    end
    initial begin
        #50000;
        bad_count++;
        give_verdict();
    end
endmodule : can_expander_msg_handler_bench
`default_nettype wire
